//--- include/desc_dispatch_defs.svh
// constants for the descriptor dispatch block
`ifndef DESC_DISPATCH_DEFS_SVH
`define DESC_DISPATCH_DEFS_SVH

// ============================================================
// descriptor layout
`define DESC_W 174
`define DESC_DW 6
`define DESC_LAST_DW 4'h5
`define IMM_BIT 146
`define SIZE_MSB 145
`define SIZE_LSB 128
`define IMM_MAX_DW 18'h00002

// ============================================================
// controller address window, byte addresses
`define CTRL_BASE 24'h00ff00
`define CTRL_BASE_MSB 31
`define CTRL_BASE_LSB 8
`define QSEL_MSB 7
`define QSEL_LSB 6
`define DWIDX_MSB 5
`define DWIDX_LSB 2

// ============================================================
// queue numbers
`define Q_RD_NORM 2'h0
`define Q_RD_PRIO 2'h1
`define Q_WR_NORM 2'h2
`define Q_WR_PRIO 2'h3
`define NUM_Q 4

// ============================================================
// sizing defaults
`define FIFO_DEPTH 16

`endif

//--- include/desc_pkg.sv
// types shared by the descriptor dispatch block
package desc_pkg;

  typedef struct packed
  {
    logic [13:0] rsvd;
    logic [7:0] id;
    logic [2:0] app;
    logic single_dst;
    logic single_src;
    logic immediate;
    logic [17:0] size;
    logic [63:0] dst;
    logic [63:0] src;
  } desc_t;

  typedef struct packed
  {
    logic [31:0] addr;
    logic [31:0] data;
  } dw_wr_t;

  typedef enum logic [1:0]
  {
    PK_COLLECT = 2'b01,
    PK_OFFER = 2'b10
  } pack_state_t;

endpackage

//--- core/desc_fifo.sv
// descriptor queue memory with registered head entry
`timescale 1ns/1ps
`include "desc_dispatch_defs.svh"

module desc_fifo
#(
  parameter int W = `DESC_W,
  parameter int DEPTH = `FIFO_DEPTH
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_push,
  input wire logic [W-1:0] i_data,
  output logic o_full,
  input wire logic i_pop,
  output logic o_valid,
  output logic [W-1:0] o_data
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push_ok;
  logic load;

  // head register refills from memory when it is empty or being taken and memory holds an entry
  assign o_full = (count_q == CW'(DEPTH));
  assign push_ok = i_push && !o_full;
  assign load = (count_q != '0) && (!o_valid || i_pop);

  always_ff @(posedge i_clk)
  begin
    if (push_ok)
    begin
      mem[wr_ptr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push_ok)
      begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (load)
      begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + CW'(push_ok) - CW'(load);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_valid <= 1'b0;
      o_data <= '0;
    end
    else if (load)
    begin
      o_valid <= 1'b1;
      o_data <= mem[rd_ptr_q];
    end
    else if (i_pop)
    begin
      o_valid <= 1'b0;
    end
  end

endmodule

//--- core/dword_packer.sv
// gathers dword writes into one whole descriptor
`timescale 1ns/1ps
`include "desc_dispatch_defs.svh"

module dword_packer
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire desc_pkg::dw_wr_t i_wr,
  output logic o_ready,
  output logic o_desc_valid,
  output desc_pkg::desc_t o_desc,
  output logic [1:0] o_queue,
  input wire logic i_desc_ready
);

  desc_pkg::pack_state_t state_q;
  logic [32*`DESC_DW-1:0] buf_q;
  logic [3:0] idx;

  assign idx = i_wr.addr[`DWIDX_MSB:`DWIDX_LSB];
  // no new dwords while a finished descriptor waits for its queue
  assign o_ready = (state_q == desc_pkg::PK_COLLECT);
  assign o_desc_valid = (state_q == desc_pkg::PK_OFFER);
  assign o_desc = desc_pkg::desc_t'(buf_q[`DESC_W-1:0]);

  // dwords past the descriptor are slot padding and are dropped
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      buf_q <= '0;
    end
    else if (i_valid && o_ready && (idx < 4'(`DESC_DW)))
    begin
      buf_q[32*idx +: 32] <= i_wr.data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= desc_pkg::PK_COLLECT;
      o_queue <= 2'h0;
    end
    else
    begin
      case (state_q)
        desc_pkg::PK_COLLECT:
        begin
          // the top dword closes the descriptor
          if (i_valid && idx == `DESC_LAST_DW)
          begin
            state_q <= desc_pkg::PK_OFFER;
            o_queue <= i_wr.addr[`QSEL_MSB:`QSEL_LSB];
          end
        end
        desc_pkg::PK_OFFER:
        begin
          if (i_desc_ready)
          begin
            state_q <= desc_pkg::PK_COLLECT;
          end
        end
        default:
        begin
          state_q <= desc_pkg::PK_COLLECT;
        end
      endcase
    end
  end

endmodule

//--- core/descriptor_dma_dispatch.sv
// descriptor dispatch controller between host writes and the data movers
`timescale 1ns/1ps
`include "desc_dispatch_defs.svh"

// How it works
// - read mover completion data goes to local memory
// - seed descriptor from bursting port reaches read mover
// - fetched table entries land in controller queues
// - read descriptors leave only while read mover ready
// - read mover writes fetched data to local address
// - fetched immediate descriptor enters write-mover queue
// - immediate write dispatched to write mover signals done
// - write mover reads local memory through read path
// - write descriptors leave only while write mover ready
// - write mover fetches local data for host writes
// - write table ends with inline immediate write
// - immediate bit on a write queue means one or two dword payload
// - size field counts dwords, zero is refused
module descriptor_dma_dispatch
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
)
(
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  // bursting master port writes
  input wire logic I_BURST_WR_VALID,
  input wire logic [31:0] I_BURST_WR_ADDR,
  input wire logic [31:0] I_BURST_WR_DATA,
  output logic O_BURST_WR_READY,
  // read mover write master
  input wire logic I_RDM_WR_VALID,
  input wire logic [31:0] I_RDM_WR_ADDR,
  input wire logic [31:0] I_RDM_WR_DATA,
  output logic O_RDM_WR_READY,
  // local memory write side
  output logic O_LM_WR_VALID,
  output logic [31:0] O_LM_WR_ADDR,
  output logic [31:0] O_LM_WR_DATA,
  input wire logic I_LM_WR_READY,
  // write mover read master and local memory read side
  input wire logic I_WDM_RD_VALID,
  input wire logic [31:0] I_WDM_RD_ADDR,
  output logic O_WDM_RD_READY,
  output logic O_LM_RD_VALID,
  output logic [31:0] O_LM_RD_ADDR,
  input wire logic I_LM_RD_READY,
  input wire logic I_LM_RD_DATA_VALID,
  input wire logic [31:0] I_LM_RD_DATA,
  output logic O_WDM_RD_DATA_VALID,
  output logic [31:0] O_WDM_RD_DATA,
  // descriptor queues of the movers
  output logic O_RD_NORM_VALID,
  output desc_pkg::desc_t O_RD_NORM_DESC,
  input wire logic I_RD_NORM_READY,
  output logic O_RD_PRIO_VALID,
  output desc_pkg::desc_t O_RD_PRIO_DESC,
  input wire logic I_RD_PRIO_READY,
  output logic O_WR_NORM_VALID,
  output desc_pkg::desc_t O_WR_NORM_DESC,
  input wire logic I_WR_NORM_READY,
  output logic O_WR_PRIO_VALID,
  output desc_pkg::desc_t O_WR_PRIO_DESC,
  input wire logic I_WR_PRIO_READY,
  // status pulses
  output logic O_IMM_DONE,
  output logic O_DROP
);

  // ============================================================
  // address decode
  logic burst_hit;
  logic rdm_hit;
  logic burst_pk_ready;
  logic rdm_pk_ready;
  logic lm_take;
  logic lm_v_q;

  assign burst_hit = (I_BURST_WR_ADDR[`CTRL_BASE_MSB:`CTRL_BASE_LSB] == `CTRL_BASE);
  assign rdm_hit = (I_RDM_WR_ADDR[`CTRL_BASE_MSB:`CTRL_BASE_LSB] == `CTRL_BASE);

  // bursting writes outside the window are taken and discarded
  assign O_BURST_WR_READY = burst_hit ? burst_pk_ready : 1'b1;
  assign O_RDM_WR_READY = rdm_hit ? rdm_pk_ready : (!lm_v_q || I_LM_WR_READY);
  assign lm_take = I_RDM_WR_VALID && !rdm_hit && O_RDM_WR_READY;

  // ============================================================
  // read mover data into local memory, one register stage
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      lm_v_q <= 1'b0;
      O_LM_WR_ADDR <= 32'h0000_0000;
      O_LM_WR_DATA <= 32'h0000_0000;
    end
    else if (lm_take)
    begin
      lm_v_q <= 1'b1;
      O_LM_WR_ADDR <= I_RDM_WR_ADDR;
      O_LM_WR_DATA <= I_RDM_WR_DATA;
    end
    else if (I_LM_WR_READY)
    begin
      lm_v_q <= 1'b0;
    end
  end

  assign O_LM_WR_VALID = lm_v_q;

  // ============================================================
  // write mover reads of local memory
  assign O_LM_RD_VALID = I_WDM_RD_VALID;
  assign O_LM_RD_ADDR = I_WDM_RD_ADDR;
  assign O_WDM_RD_READY = I_LM_RD_READY;

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_WDM_RD_DATA_VALID <= 1'b0;
      O_WDM_RD_DATA <= 32'h0000_0000;
    end
    else
    begin
      O_WDM_RD_DATA_VALID <= I_LM_RD_DATA_VALID;
      if (I_LM_RD_DATA_VALID)
      begin
        O_WDM_RD_DATA <= I_LM_RD_DATA;
      end
    end
  end

  // ============================================================
  // descriptor assembly, one packer per source
  desc_pkg::dw_wr_t burst_wr;
  desc_pkg::dw_wr_t rdm_wr;
  desc_pkg::desc_t burst_desc;
  desc_pkg::desc_t rdm_desc;
  logic burst_dv;
  logic rdm_dv;
  logic [1:0] burst_q;
  logic [1:0] rdm_q;
  logic burst_take;
  logic rdm_take;

  assign burst_wr = '{addr: I_BURST_WR_ADDR, data: I_BURST_WR_DATA};
  assign rdm_wr = '{addr: I_RDM_WR_ADDR, data: I_RDM_WR_DATA};

  dword_packer u_burst_pack
  (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RESET_N),
    .i_valid(I_BURST_WR_VALID && burst_hit),
    .i_wr(burst_wr),
    .o_ready(burst_pk_ready),
    .o_desc_valid(burst_dv),
    .o_desc(burst_desc),
    .o_queue(burst_q),
    .i_desc_ready(burst_take)
  );

  dword_packer u_rdm_pack
  (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RESET_N),
    .i_valid(I_RDM_WR_VALID && rdm_hit),
    .i_wr(rdm_wr),
    .o_ready(rdm_pk_ready),
    .o_desc_valid(rdm_dv),
    .o_desc(rdm_desc),
    .o_queue(rdm_q),
    .i_desc_ready(rdm_take)
  );

  // ============================================================
  // commit into queues; table traffic beats the seed
  desc_pkg::desc_t c_desc;
  logic [1:0] c_q;
  logic c_valid;
  logic c_bad;
  logic c_accept;
  logic [`NUM_Q-1:0] q_full;
  logic [`NUM_Q-1:0] q_push;
  logic [`NUM_Q-1:0] q_pop;
  logic [`NUM_Q-1:0] q_valid;
  desc_pkg::desc_t q_data [`NUM_Q];

  assign c_valid = rdm_dv || burst_dv;
  assign c_desc = rdm_dv ? rdm_desc : burst_desc;
  assign c_q = rdm_dv ? rdm_q : burst_q;

  // malformed descriptors are dropped rather than stalling the table
  always_comb
  begin
    c_bad = (c_desc.size == 18'h00000);
    if (c_q[1] && c_desc.immediate && c_desc.size > `IMM_MAX_DW)
    begin
      c_bad = 1'b1;
    end
  end

  assign c_accept = c_valid && (c_bad || !q_full[c_q]);
  assign rdm_take = c_accept && rdm_dv;
  assign burst_take = c_accept && !rdm_dv;

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_DROP <= 1'b0;
    end
    else
    begin
      O_DROP <= c_accept && c_bad;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_Q; gi++)
    begin : g_queue
      assign q_push[gi] = c_accept && !c_bad && (c_q == 2'(gi));
      desc_fifo #(.W(`DESC_W), .DEPTH(FIFO_DEPTH)) u_fifo
      (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RESET_N),
        .i_push(q_push[gi]),
        .i_data(c_desc),
        .o_full(q_full[gi]),
        .i_pop(q_pop[gi]),
        .o_valid(q_valid[gi]),
        .o_data(q_data[gi])
      );
    end
  endgenerate

  // ============================================================
  // dispatch to the movers
  // normal entry is held back while a priority entry can go
  assign O_RD_PRIO_VALID = q_valid[`Q_RD_PRIO];
  assign O_RD_NORM_VALID = q_valid[`Q_RD_NORM] && !(q_valid[`Q_RD_PRIO] && I_RD_PRIO_READY);
  assign O_WR_PRIO_VALID = q_valid[`Q_WR_PRIO];
  assign O_WR_NORM_VALID = q_valid[`Q_WR_NORM] && !(q_valid[`Q_WR_PRIO] && I_WR_PRIO_READY);
  assign O_RD_NORM_DESC = q_data[`Q_RD_NORM];
  assign O_RD_PRIO_DESC = q_data[`Q_RD_PRIO];
  assign O_WR_NORM_DESC = q_data[`Q_WR_NORM];
  assign O_WR_PRIO_DESC = q_data[`Q_WR_PRIO];

  assign q_pop[`Q_RD_NORM] = O_RD_NORM_VALID && I_RD_NORM_READY;
  assign q_pop[`Q_RD_PRIO] = O_RD_PRIO_VALID && I_RD_PRIO_READY;
  assign q_pop[`Q_WR_NORM] = O_WR_NORM_VALID && I_WR_NORM_READY;
  assign q_pop[`Q_WR_PRIO] = O_WR_PRIO_VALID && I_WR_PRIO_READY;

  // completion marker: an immediate write handed to the write mover
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_IMM_DONE <= 1'b0;
    end
    else
    begin
      O_IMM_DONE <= (q_pop[`Q_WR_NORM] && O_WR_NORM_DESC.immediate) ||
                    (q_pop[`Q_WR_PRIO] && O_WR_PRIO_DESC.immediate);
    end
  end

  // ============================================================
  // assertions
  AST_RD_HOLD: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    q_valid[`Q_RD_NORM] && !I_RD_NORM_READY |=> q_valid[`Q_RD_NORM] && $stable(O_RD_NORM_DESC))
    else $error("read normal descriptor lost without ready");

  AST_WR_HOLD: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    q_valid[`Q_WR_NORM] && !I_WR_NORM_READY |=> q_valid[`Q_WR_NORM] && $stable(O_WR_NORM_DESC))
    else $error("write normal descriptor lost without ready");

  AST_PRIO_FIRST: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    O_WR_PRIO_VALID && I_WR_PRIO_READY && q_valid[`Q_WR_NORM] |=>
      q_valid[`Q_WR_NORM] && $stable(O_WR_NORM_DESC))
    else $error("normal write descriptor went before priority one");

  AST_IMM_DONE: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    O_IMM_DONE |-> $past(q_pop[`Q_WR_NORM] || q_pop[`Q_WR_PRIO]))
    else $error("done pulse without a write dispatch");

  AST_IMM_LEN: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    (q_push[`Q_WR_NORM] || q_push[`Q_WR_PRIO]) && c_desc.immediate |->
      c_desc.size == 18'h00001 || c_desc.size == 18'h00002)
    else $error("immediate write queued with bad length");

  AST_ZERO_DROP: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    c_valid && c_desc.size == 18'h00000 |-> q_push == 4'h0 ##1 O_DROP)
    else $error("zero size descriptor not dropped");

  AST_SEED_FWD: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    burst_take && !c_bad && burst_q == `Q_RD_PRIO |-> ##[1:2] q_valid[`Q_RD_PRIO])
    else $error("seed descriptor did not reach read priority queue");

  AST_TABLE_IN: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    rdm_take && !c_bad |-> q_push[rdm_q])
    else $error("fetched descriptor not queued");

  AST_LM_WR: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    lm_take |=> O_LM_WR_VALID && O_LM_WR_DATA == $past(I_RDM_WR_DATA))
    else $error("read mover data not forwarded to local memory");

  AST_RD_DATA: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    I_LM_RD_DATA_VALID |=> O_WDM_RD_DATA_VALID && O_WDM_RD_DATA == $past(I_LM_RD_DATA))
    else $error("local read data not returned to write mover");

endmodule

//--- dv/mover_model.sv
// behavioural model of the data movers' descriptor intake
`timescale 1ns/1ps
`include "desc_dispatch_defs.svh"

module mover_model
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_stall,
  input wire logic [3:0] i_valid,
  input wire logic [4*`DESC_W-1:0] i_desc,
  output logic [3:0] o_ready,
  output logic [7:0] o_tot,
  output logic [1:0] o_last_q,
  output desc_pkg::desc_t o_last
);
  // ==========
  // intake
  // the stall mask lets the bench make a mover answer late or never
  assign o_ready = ~i_stall & {4{i_rst_n}};
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tot <= 8'h00;
      o_last_q <= 2'h0;
      o_last <= '0;
    end
    else
    begin
      // one pop per edge is assumed; the bench releases one mover at a time, except both write movers in t_prio, where priority holds normal back
      for (int k = 0; k < 4; k++)
      begin
        if (i_valid[k] && o_ready[k])
        begin
          o_tot <= o_tot + 8'h01;
          o_last_q <= 2'(k);
          o_last <= i_desc[k*`DESC_W +: `DESC_W];
        end
      end
    end
  end
endmodule

//--- dv/descriptor_dma_dispatch_test.sv
// self-checking bench for the descriptor dispatch controller
`timescale 1ns/1ps
`include "desc_dispatch_defs.svh"

module descriptor_dma_dispatch_test;
  logic clk = 1'b0, rst_n = 1'b0, wrv = 1'b0, wrs = 1'b0, lm_rdy = 1'b1;
  logic wdv = 1'b0, lr_rdy = 1'b0, ldv = 1'b0;
  logic [31:0] wra = '0, wrd = '0, wda = '0, ld = '0;
  logic [3:0] stall = 4'hf;
  logic burst_rdy, rdm_rdy, lm_v, wd_rdy, lr_v, wd_v, imm, drop;
  logic [31:0] lm_a, lm_d, lr_a, wd_d;
  logic [3:0] qv, qr;
  logic [7:0] tot;
  logic [1:0] last_q;
  desc_pkg::desc_t qd0, qd1, qd2, qd3, last;
  int bad_count = 0, checked = 0, imm_n = 0, drop_n = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (imm === 1'b1)
      imm_n <= imm_n + 1;
    if (drop === 1'b1)
      drop_n <= drop_n + 1;
  end
  // ==========
  // instances
  descriptor_dma_dispatch #(.FIFO_DEPTH(2)) uut
  (
    .I_CORE_CLK(clk), .I_RESET_N(rst_n),
    .I_BURST_WR_VALID(wrv && !wrs), .I_BURST_WR_ADDR(wra), .I_BURST_WR_DATA(wrd),
    .O_BURST_WR_READY(burst_rdy),
    .I_RDM_WR_VALID(wrv && wrs), .I_RDM_WR_ADDR(wra), .I_RDM_WR_DATA(wrd),
    .O_RDM_WR_READY(rdm_rdy),
    .O_LM_WR_VALID(lm_v), .O_LM_WR_ADDR(lm_a), .O_LM_WR_DATA(lm_d), .I_LM_WR_READY(lm_rdy),
    .I_WDM_RD_VALID(wdv), .I_WDM_RD_ADDR(wda), .O_WDM_RD_READY(wd_rdy),
    .O_LM_RD_VALID(lr_v), .O_LM_RD_ADDR(lr_a), .I_LM_RD_READY(lr_rdy),
    .I_LM_RD_DATA_VALID(ldv), .I_LM_RD_DATA(ld),
    .O_WDM_RD_DATA_VALID(wd_v), .O_WDM_RD_DATA(wd_d),
    .O_RD_NORM_VALID(qv[0]), .O_RD_NORM_DESC(qd0), .I_RD_NORM_READY(qr[0]),
    .O_RD_PRIO_VALID(qv[1]), .O_RD_PRIO_DESC(qd1), .I_RD_PRIO_READY(qr[1]),
    .O_WR_NORM_VALID(qv[2]), .O_WR_NORM_DESC(qd2), .I_WR_NORM_READY(qr[2]),
    .O_WR_PRIO_VALID(qv[3]), .O_WR_PRIO_DESC(qd3), .I_WR_PRIO_READY(qr[3]),
    .O_IMM_DONE(imm), .O_DROP(drop)
  );
  mover_model movers
  (
    .i_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_valid(qv),
    .i_desc({qd3, qd2, qd1, qd0}), .o_ready(qr), .o_tot(tot), .o_last_q(last_q),
    .o_last(last)
  );
  // ==========
  // helpers
  task automatic check(input logic [173:0] e, input logic [173:0] g);
    checked++;
    if (e !== g)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hang();
    check(1, 0);
    final_report();
  endtask
  function automatic desc_pkg::desc_t mk(input logic [17:0] sz, input logic im,
                                         input logic [7:0] id);
    desc_pkg::desc_t d;
    d = '0;
    d.size = sz;
    d.immediate = im;
    d.id = id;
    d.src = {32'h0, 24'h00a5c3, id};
    d.dst = 64'h0000_1000 + id;
    return d;
  endfunction
  // request held from a falling edge until ready is seen at a rising edge
  task automatic dw_wr(input logic src, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(negedge clk);
    wrv = 1'b1;
    wrs = src;
    wra = a;
    wrd = d;
    #1;
    n = 0;
    while ((wrs ? rdm_rdy : burst_rdy) !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 50)
      hang();
    @(posedge clk);
  endtask
  task automatic put_desc(input logic src, input logic [1:0] q, input desc_pkg::desc_t d);
    logic [191:0] p;
    p = {18'h0, d};
    dw_wr(src, {`CTRL_BASE, q, 4'h9, 2'h0}, 32'hdead_beef);
    for (int i = 0; i < `DESC_DW; i++)
      dw_wr(src, {`CTRL_BASE, q, 4'(i), 2'h0}, p[32*i +: 32]);
    @(negedge clk);
    wrv = 1'b0;
  endtask
  task automatic take(input logic [1:0] q, input desc_pkg::desc_t d);
    logic [7:0] t0;
    int n;
    t0 = tot;
    n = 0;
    while (tot === t0 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 40)
      hang();
    check(q, last_q);
    check(d, last);
  endtask
  // ==========
  // scenarios
  task automatic t_seed();
    desc_pkg::desc_t s;
    logic [7:0] t0;
    s = mk(18'h00040, 1'b0, 8'h01);
    s.dst = {32'h0, `CTRL_BASE, 8'h80};
    t0 = tot;
    put_desc(1'b0, `Q_RD_PRIO, s);
    repeat (4) @(negedge clk);
    check(1'b1, qv[1]);
    check(t0, tot);
    check(s, qd1);
    stall = 4'hd;
    take(`Q_RD_PRIO, s);
    stall = 4'hf;
  endtask
  task automatic t_table();
    desc_pkg::desc_t r, w;
    int n0;
    r = mk(18'h00010, 1'b0, 8'h02);
    w = mk(18'h00002, 1'b1, 8'h03);
    put_desc(1'b1, `Q_RD_NORM, r);
    put_desc(1'b1, `Q_WR_NORM, w);
    repeat (4) @(negedge clk);
    check(r, qd0);
    check(w, qd2);
    n0 = imm_n;
    stall = 4'he;
    take(`Q_RD_NORM, r);
    stall = 4'hb;
    take(`Q_WR_NORM, w);
    @(negedge clk);
    check(n0 + 1, imm_n);
    stall = 4'hf;
  endtask
  task automatic t_prio();
    desc_pkg::desc_t a, b;
    int n0;
    a = mk(18'h00020, 1'b0, 8'h04);
    b = mk(18'h00001, 1'b1, 8'h05);
    put_desc(1'b0, `Q_WR_NORM, a);
    put_desc(1'b0, `Q_WR_PRIO, b);
    repeat (4) @(negedge clk);
    check(2'b11, qv[3:2]);
    n0 = imm_n;
    stall = 4'h3;
    take(`Q_WR_PRIO, b);
    take(`Q_WR_NORM, a);
    @(negedge clk);
    check(n0 + 1, imm_n);
    stall = 4'hf;
  endtask
  // queue of depth two plus head holds three; the fourth waits with ready low
  task automatic t_full();
    desc_pkg::desc_t d[4];
    for (int i = 0; i < 4; i++)
    begin
      d[i] = mk(18'h00008, 1'b0, 8'(8'h10 + i));
      put_desc(1'b0, `Q_RD_NORM, d[i]);
    end
    repeat (4) @(negedge clk);
    wra = {`CTRL_BASE, 8'h00};
    #1;
    check(1'b0, burst_rdy);
    stall = 4'he;
    for (int i = 0; i < 4; i++)
      take(`Q_RD_NORM, d[i]);
    stall = 4'hf;
  endtask
  task automatic t_drop();
    int n0;
    n0 = drop_n;
    put_desc(1'b0, `Q_RD_NORM, mk(18'h00000, 1'b0, 8'h06));
    put_desc(1'b1, `Q_WR_PRIO, mk(18'h00003, 1'b1, 8'h07));
    repeat (4) @(negedge clk);
    check(n0 + 2, drop_n);
    check(4'h0, qv);
  endtask
  task automatic t_lwr();
    lm_rdy = 1'b0;
    dw_wr(1'b1, 32'h0000_0040, 32'h1234_5678);
    @(negedge clk);
    wrv = 1'b0;
    check(1'b1, lm_v);
    check(32'h0000_0040, lm_a);
    check(32'h1234_5678, lm_d);
    repeat (2) @(negedge clk);
    check(1'b1, lm_v);
    lm_rdy = 1'b1;
    @(negedge clk);
    check(1'b0, lm_v);
  endtask
  task automatic t_lrd();
    @(negedge clk);
    wdv = 1'b1;
    wda = 32'h0000_0100;
    lr_rdy = 1'b1;
    #1;
    check(1'b1, lr_v);
    check(32'h0000_0100, lr_a);
    check(1'b1, wd_rdy);
    @(negedge clk);
    wdv = 1'b0;
    lr_rdy = 1'b0;
    ldv = 1'b1;
    ld = 32'h0bad_f00d;
    @(negedge clk);
    ldv = 1'b0;
    check(1'b1, wd_v);
    check(32'h0bad_f00d, wd_d);
    @(negedge clk);
    check(1'b0, wd_v);
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_seed();
    t_table();
    t_prio();
    t_full();
    t_drop();
    t_lwr();
    t_lrd();
    final_report();
  end
endmodule
